// [logic/lgi_glyph_top.sv]
// Glyph, icon and cursor refresh with host register port and init sequencing.
// Assumes synchronous inputs, an external asynchronous fixed glyph ROM, one 10 MHz clock.
`timescale 1ns/1ps
module lgi_glyph_top
	import lgi_pkg::*;
#(
	parameter int LOW_CYC = PIN_LOW_CYC,
	parameter int POWER_CYC = POWER_BUSY_CYC,
	parameter int PIN_CYC = PIN_BUSY_CYC,
	parameter int BLINK_CYC = BLINK_HALF_CYC
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic reset_pin_b_in,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic [DATA_W-1:0] reg_wdata_in,
	input wire logic reg_wr_in,
	input wire logic reg_rd_in,
	output logic [DATA_W-1:0] reg_rdata_out,
	// Status
	output logic internal_operation_flag_out,
	// Fixed glyph ROM
	output logic [7:0] fixed_glyph_code_out,
	output logic [2:0] fixed_glyph_row_out,
	input wire logic [GLYPH_W-1:0] fixed_glyph_row_in,
	// Panel drivers
	output logic [NUM_COLS-1:0] column_driver_output_out,
	output logic [NUM_TEXT_ROWS-1:0] row_driver_out,
	output logic icon_row_driver_out
);
	localparam int BCW = $clog2(BLINK_CYC + 1);

	lgi_scan_if scan ();

	logic [7:0] display_text_memory [TEXT_DEPTH];
	logic [GLYPH_W-1:0] user_glyph_memory [GLYPH_DEPTH];

	logic disp_on_reg;
	logic cursor_on_reg;
	logic blink_on_reg;
	logic two_line_reg;
	logic ptr_glyph_reg;
	logic [6:0] cursor_address_pointer_reg;
	logic seq_clear;
	logic busy;
	logic [5:0] ptr_text;
	logic ptr_tvalid;
	logic [4:0] ptr_tidx;
	logic access_ok;
	logic wr_ctrl;
	logic wr_ptr;
	logic wr_data;
	logic rd_data;
	logic soft_init;
	logic data_step;

	lgi_scan_t scan_state_reg;
	logic [4:0] row_reg;
	logic [3:0] char_reg;
	logic [2:0] dot_reg;
	logic [7:0] code_reg;
	logic [BCW-1:0] blink_cnt_reg;
	logic blink_phase_reg;
	logic [4:0] scan_idx;
	logic cursor_hit;
	logic [GLYPH_W-1:0] user_row;
	logic [GLYPH_W-1:0] pattern_row;
	logic [GLYPH_W-1:0] icon_word;
	logic [2:0] bit_sel;
	logic pixel;

	lgi_reset_seq #(
		.LOW_CYC(LOW_CYC),
		.POWER_CYC(POWER_CYC),
		.PIN_CYC(PIN_CYC)
	) u_reset_seq (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.reset_pin_b_in(reset_pin_b_in),
		.seq_clear_out(seq_clear),
		.busy_out(busy)
	);

	lgi_col_shift #(
		.COLS(NUM_COLS)
	) u_col_shift (
		.core_clk_in(core_clk_in),
		.rst_b_in(rst_b_in),
		.scan(scan),
		.column_driver_out(column_driver_output_out),
		.row_driver_out(row_driver_out),
		.icon_row_driver_out(icon_row_driver_out)
	);

	// Host decode; writes and data accesses are dropped while busy
	assign access_ok = !busy && !seq_clear;
	assign wr_ctrl = reg_wr_in && access_ok && (reg_addr_in == REG_CTRL);
	assign wr_ptr = reg_wr_in && access_ok && (reg_addr_in == REG_POINTER);
	assign wr_data = reg_wr_in && access_ok && (reg_addr_in == REG_DATA);
	assign rd_data = reg_rd_in && access_ok && (reg_addr_in == REG_DATA);
	assign soft_init = wr_ctrl && reg_wdata_in[CTRL_SOFT_INIT_BIT];
	assign data_step = wr_data || rd_data;
	assign ptr_text = lgi_text_index(cursor_address_pointer_reg, two_line_reg);
	assign ptr_tvalid = ptr_text[5];
	assign ptr_tidx = ptr_text[4:0];

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			internal_operation_flag_out <= 1'b1;
		end else begin
			internal_operation_flag_out <= busy || seq_clear;
		end
	end

	// Display controls; two_line clears to single-line on any reset
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			disp_on_reg <= CTRL_DISP_RST;
			cursor_on_reg <= CTRL_CURSOR_RST;
			blink_on_reg <= CTRL_BLINK_RST;
			two_line_reg <= CTRL_TWO_LINE_RST;
		end else if (seq_clear) begin
			disp_on_reg <= CTRL_DISP_RST;
			cursor_on_reg <= CTRL_CURSOR_RST;
			blink_on_reg <= CTRL_BLINK_RST;
			two_line_reg <= CTRL_TWO_LINE_RST;
		end else if (wr_ctrl) begin
			disp_on_reg <= reg_wdata_in[CTRL_DISP_BIT];
			cursor_on_reg <= reg_wdata_in[CTRL_CURSOR_BIT];
			blink_on_reg <= reg_wdata_in[CTRL_BLINK_BIT];
			two_line_reg <= reg_wdata_in[CTRL_TWO_LINE_BIT];
		end
	end

	// Pointer; steps after each data access, wrapping within the 32 glyph rows; text addresses count on past the text range
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			ptr_glyph_reg <= 1'b0;
			cursor_address_pointer_reg <= PTR_RST;
		end else if (seq_clear) begin
			ptr_glyph_reg <= 1'b0;
			cursor_address_pointer_reg <= PTR_RST;
		end else if (wr_ptr) begin
			ptr_glyph_reg <= reg_wdata_in[PTR_GLYPH_BIT];
			cursor_address_pointer_reg <= reg_wdata_in[6:0];
		end else if (data_step) begin
			if (ptr_glyph_reg) begin
				cursor_address_pointer_reg <= {2'b00, cursor_address_pointer_reg[4:0] + 5'h01};
			end else begin
				cursor_address_pointer_reg <= cursor_address_pointer_reg + 7'h01;
			end
		end
	end

	always_ff @(posedge core_clk_in) begin
		if (wr_data && !ptr_glyph_reg && ptr_tvalid) begin
			display_text_memory[ptr_tidx] <= reg_wdata_in;
		end
	end

	// Glyph memory survives both resets; only software init clears it
	always_ff @(posedge core_clk_in) begin
		if (soft_init) begin
			for (int i = 0; i < GLYPH_DEPTH; i++) begin
				user_glyph_memory[i] <= '0;
			end
		end else if (wr_data && ptr_glyph_reg) begin
			user_glyph_memory[cursor_address_pointer_reg[4:0]] <= reg_wdata_in[GLYPH_W-1:0];
		end
	end

	// Read data stands for the one cycle after the strobe
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			reg_rdata_out <= '0;
		end else if (reg_rd_in) begin
			unique case (reg_addr_in)
				REG_CTRL: reg_rdata_out <= {4'h0, two_line_reg, blink_on_reg, cursor_on_reg,
					disp_on_reg};
				REG_POINTER: reg_rdata_out <= {busy || seq_clear, cursor_address_pointer_reg};
				REG_DATA: begin
					if (!access_ok) begin
						reg_rdata_out <= '0;
					end else if (ptr_glyph_reg) begin
						reg_rdata_out <= {3'h0, user_glyph_memory[cursor_address_pointer_reg[4:0]]};
					end else if (ptr_tvalid) begin
						reg_rdata_out <= display_text_memory[ptr_tidx];
					end else begin
						reg_rdata_out <= '0;
					end
				end
				default: reg_rdata_out <= '0;
			endcase
		end else begin
			reg_rdata_out <= '0;
		end
	end

	// Blink rate from a divider enable
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			blink_cnt_reg <= '0;
			blink_phase_reg <= 1'b0;
		end else if (blink_cnt_reg == BCW'(BLINK_CYC - 1)) begin
			blink_cnt_reg <= '0;
			blink_phase_reg <= !blink_phase_reg;
		end else begin
			blink_cnt_reg <= blink_cnt_reg + 1'b1;
		end
	end

	// Refresh path reads the memories on its own port, never waiting on the host
	assign scan_idx = (row_reg[3] ? LINE2_OFFSET : 5'h00) + {1'b0, char_reg};
	assign cursor_hit = ptr_tvalid && (ptr_tidx == scan_idx);
	assign user_row = user_glyph_memory[{code_reg[1:0], row_reg[2:0]}];
	assign pattern_row = (code_reg[7:4] == 4'h0) ? user_row : fixed_glyph_row_in;
	assign icon_word = user_glyph_memory[ICON_BASE + {1'b0, LAST_CHAR - char_reg}];
	assign bit_sel = LAST_DOT - dot_reg;

	always_comb begin
		pixel = 1'b0;
		if (row_reg == ICON_ROW) begin
			pixel = icon_word[bit_sel];
		end else begin
			pixel = pattern_row[bit_sel];
			if (row_reg[2:0] == CURSOR_PROW && cursor_on_reg && cursor_hit) begin
				pixel = 1'b1;
			end
			if (blink_on_reg && blink_phase_reg && cursor_hit) begin
				pixel = 1'b1;
			end
		end
		pixel = pixel && disp_on_reg;
	end

	assign scan.shift_en = (scan_state_reg == LGI_SCAN_SHIFT);
	assign scan.shift_bit = pixel;
	assign scan.latch_en = (scan_state_reg == LGI_SCAN_LATCH);
	assign scan.row_idx = row_reg;

	// Per row: fetch each code, shift its five dots, latch after the last column
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			scan_state_reg <= LGI_SCAN_FETCH;
			row_reg <= '0;
			char_reg <= '0;
			dot_reg <= '0;
			code_reg <= '0;
			fixed_glyph_code_out <= '0;
			fixed_glyph_row_out <= '0;
		end else begin
			unique case (scan_state_reg)
				LGI_SCAN_FETCH: begin
					code_reg <= display_text_memory[scan_idx];
					fixed_glyph_code_out <= display_text_memory[scan_idx];
					fixed_glyph_row_out <= row_reg[2:0];
					dot_reg <= '0;
					scan_state_reg <= LGI_SCAN_SHIFT;
				end
				LGI_SCAN_SHIFT: begin
					if (dot_reg != LAST_DOT) begin
						dot_reg <= dot_reg + 3'h1;
					end else if (char_reg == LAST_CHAR) begin
						scan_state_reg <= LGI_SCAN_LATCH;
					end else begin
						char_reg <= char_reg + 4'h1;
						scan_state_reg <= LGI_SCAN_FETCH;
					end
				end
				LGI_SCAN_LATCH: begin
					char_reg <= '0;
					row_reg <= (row_reg == ICON_ROW) ? 5'h00 : row_reg + 5'h01;
					scan_state_reg <= LGI_SCAN_FETCH;
				end
				default: scan_state_reg <= LGI_SCAN_FETCH;
			endcase
		end
	end
endmodule

// [logic/lgi_pkg.sv]
// Shared constants, types and address mapping for the glyph, icon, cursor and init block.
// Assumes a single 10 MHz core clock; all cycle counts below are derived from that rate.
package lgi_pkg;

	// Clock rate and printed times
	localparam int CLK_HZ = 10_000_000;
	localparam int POWER_BUSY_MS = 10;
	localparam int PIN_BUSY_MS = 10;
	localparam int PIN_LOW_US = 1200;
	localparam int BLINK_HALF_MS = 400;
	localparam int POWER_BUSY_CYC = (CLK_HZ / 1000) * POWER_BUSY_MS;
	localparam int PIN_BUSY_CYC = (CLK_HZ / 1000) * PIN_BUSY_MS;
	localparam int PIN_LOW_CYC = ((CLK_HZ / 1000) * PIN_LOW_US + 999) / 1000;
	localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_HALF_MS;

	// Register bus
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam logic [3:0] REG_CTRL = 4'h0;
	localparam logic [3:0] REG_POINTER = 4'h1;
	localparam logic [3:0] REG_DATA = 4'h2;

	// Control register fields
	localparam int CTRL_DISP_BIT = 0;
	localparam int CTRL_CURSOR_BIT = 1;
	localparam int CTRL_BLINK_BIT = 2;
	localparam int CTRL_TWO_LINE_BIT = 3;
	localparam int CTRL_SOFT_INIT_BIT = 7;
	localparam logic CTRL_DISP_RST = 1'b0;
	localparam logic CTRL_CURSOR_RST = 1'b0;
	localparam logic CTRL_BLINK_RST = 1'b0;
	localparam logic CTRL_TWO_LINE_RST = 1'b0;

	// Pointer register fields
	localparam int PTR_GLYPH_BIT = 7;
	localparam int PTR_BUSY_BIT = 7;
	localparam logic [6:0] PTR_RST = 7'h00;

	// Panel geometry and memories
	localparam int NUM_COLS = 60;
	localparam int NUM_TEXT_ROWS = 16;
	localparam int ROW_W = 5;
	localparam logic [4:0] ICON_ROW = 5'h10;
	localparam logic [3:0] LAST_CHAR = 4'hb;
	localparam logic [2:0] LAST_DOT = 3'h4;
	localparam logic [4:0] LINE2_OFFSET = 5'h0c;
	localparam logic [6:0] LINE2_BASE = 7'h40;
	localparam logic [6:0] ONE_LINE_LIMIT = 7'h18;
	localparam int TEXT_DEPTH = 24;
	localparam int GLYPH_DEPTH = 32;
	localparam int GLYPH_W = 5;
	localparam logic [4:0] ICON_BASE = 5'h14;
	localparam logic [2:0] CURSOR_PROW = 3'h7;

	typedef enum logic [1:0] {LGI_SCAN_FETCH, LGI_SCAN_SHIFT, LGI_SCAN_LATCH} lgi_scan_t;

	// Pointer value to text slot: {valid, slot}; one-line slots 0..23, two-line 0..11 / 12..23
	function automatic logic [5:0] lgi_text_index(input logic [6:0] a, input logic two_line);
		logic [5:0] r;
		r = 6'h00;
		if (two_line) begin
			if ((a & ~LINE2_BASE) <= 7'(LAST_CHAR)) begin
				r = {1'b1, (a[6] ? LINE2_OFFSET : 5'h00) + {1'b0, a[3:0]}};
			end
		end else if (a < ONE_LINE_LIMIT) begin
			r = {1'b1, a[4:0]};
		end
		return r;
	endfunction

endpackage

// [logic/lgi_scan_if.sv]
// Carries the serial column pattern and row latch from the refresh engine to the drivers.
// Assumes both ends run on the core clock.
`timescale 1ns/1ps
interface lgi_scan_if;
	import lgi_pkg::*;
	logic shift_en;
	logic shift_bit;
	logic latch_en;
	logic [ROW_W-1:0] row_idx;
	modport src (output shift_en, output shift_bit, output latch_en, output row_idx);
	modport drv (input shift_en, input shift_bit, input latch_en, input row_idx);
endinterface

// [logic/lgi_col_shift.sv]
// Column shift register with output latch, and one-hot row select latched with it.
// Assumes the source shifts the first column first and pulses latch after the last.
`timescale 1ns/1ps
module lgi_col_shift
	import lgi_pkg::*;
#(
	parameter int COLS = NUM_COLS
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// Pattern stream
	lgi_scan_if.drv scan,
	// Driver levels
	output logic [COLS-1:0] column_driver_out,
	output logic [NUM_TEXT_ROWS-1:0] row_driver_out,
	output logic icon_row_driver_out
);
	logic [COLS-1:0] shift_reg;

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			shift_reg <= '0;
		end else if (scan.shift_en) begin
			shift_reg <= {scan.shift_bit, shift_reg[COLS-1:1]};
		end
	end

	// Only the latched copy reaches the glass, so shifting never shows
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			column_driver_out <= '0;
			row_driver_out <= '0;
			icon_row_driver_out <= 1'b0;
		end else if (scan.latch_en) begin
			column_driver_out <= shift_reg;
			for (int i = 0; i < NUM_TEXT_ROWS; i++) begin
				row_driver_out[i] <= (scan.row_idx == 5'(i));
			end
			icon_row_driver_out <= (scan.row_idx == ICON_ROW);
		end
	end
endmodule

// [logic/lgi_reset_seq.sv]
// Power-on and reset-pin sequencer producing the busy indication.
// Assumes the reset pin is already synchronous to the core clock.
`timescale 1ns/1ps
module lgi_reset_seq
	import lgi_pkg::*;
#(
	parameter int LOW_CYC = PIN_LOW_CYC,
	parameter int POWER_CYC = POWER_BUSY_CYC,
	parameter int PIN_CYC = PIN_BUSY_CYC
) (
	// Clock and reset
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	// Reset pin
	input wire logic reset_pin_b_in,
	// Sequence status
	output logic seq_clear_out,
	output logic busy_out
);
	localparam int LW = $clog2(LOW_CYC + 2);
	localparam int BW = $clog2(((POWER_CYC > PIN_CYC) ? POWER_CYC : PIN_CYC) + 1);
	logic [LW-1:0] low_cnt_reg;
	logic [BW-1:0] busy_cnt_reg;

	// Count the low time; arm once it is longer than the minimum
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			low_cnt_reg <= '0;
			seq_clear_out <= 1'b0;
		end else if (!reset_pin_b_in) begin
			if (low_cnt_reg != LW'(LOW_CYC)) begin
				low_cnt_reg <= low_cnt_reg + 1'b1;
			end
			if (low_cnt_reg == LW'(LOW_CYC)) begin
				seq_clear_out <= 1'b1;
			end
		end else begin
			low_cnt_reg <= '0;
			seq_clear_out <= 1'b0;
		end
	end

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			busy_cnt_reg <= BW'(POWER_CYC);
			busy_out <= 1'b1;
		end else if (seq_clear_out) begin
			busy_cnt_reg <= BW'(PIN_CYC);
			busy_out <= 1'b1;
		end else if (busy_cnt_reg != '0) begin
			busy_cnt_reg <= busy_cnt_reg - 1'b1;
			busy_out <= (busy_cnt_reg != BW'(1));
		end else begin
			busy_out <= 1'b0;
		end
	end
endmodule

// [testbench/lgi_rom_model.sv]
// Fixed glyph ROM stand-in: pattern row 0 gives the low five code bits, other rows are dark.
// Assumes the controller samples the row data combinationally from its registered address.
`timescale 1ns/1ps
module lgi_rom_model
	import lgi_pkg::*;
(
	// Address from controller
	input wire logic [7:0] code_in,
	input wire logic [2:0] row_in,
	// Row data
	output logic [GLYPH_W-1:0] row_out
);
	assign row_out = (row_in == 3'h0) ? code_in[4:0] : 5'h00;
endmodule

// [testbench/lgi_glyph_sva.sv]
// Checker on the top ports: read timing, busy sequencing, row scan and column latch.
// Assumes one clock domain; bound into every instance of the glyph top.
`timescale 1ns/1ps
module lgi_glyph_sva
	import lgi_pkg::*;
#(
	parameter int LOW_CYC = PIN_LOW_CYC,
	parameter int POWER_CYC = POWER_BUSY_CYC
) (
	// Clock and resets
	input wire logic core_clk_in,
	input wire logic rst_b_in,
	input wire logic reset_pin_b_in,
	// Register port
	input wire logic [ADDR_W-1:0] reg_addr_in,
	input wire logic reg_rd_in,
	input wire logic [DATA_W-1:0] reg_rdata_out,
	input wire logic internal_operation_flag_out,
	// Drivers
	input wire logic [NUM_COLS-1:0] column_driver_output_out,
	input wire logic [NUM_TEXT_ROWS-1:0] row_driver_out,
	input wire logic icon_row_driver_out
);
	int por_cnt;
	int low_cnt;
	int gap_cnt;
	logic seen_reg;
	logic [NUM_TEXT_ROWS:0] rows_reg;
	logic rows_chg;

	default clocking cb @(posedge core_clk_in); endclocking
	default disable iff (!rst_b_in);

	assign rows_chg = {row_driver_out, icon_row_driver_out} != rows_reg;

	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			por_cnt <= 0;
		end else if (por_cnt < POWER_CYC) begin
			por_cnt <= por_cnt + 1;
		end
	end

	// Consecutive low samples of the reset pin, saturating past the arm point
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			low_cnt <= 0;
		end else if (reset_pin_b_in) begin
			low_cnt <= 0;
		end else if (low_cnt <= LOW_CYC) begin
			low_cnt <= low_cnt + 1;
		end
	end

	// Cycles since the row select last changed
	always_ff @(posedge core_clk_in or negedge rst_b_in) begin
		if (!rst_b_in) begin
			gap_cnt <= 0;
			seen_reg <= 1'b0;
			rows_reg <= '0;
		end else begin
			rows_reg <= {row_driver_out, icon_row_driver_out};
			if (rows_chg) begin
				gap_cnt <= 0;
				seen_reg <= 1'b1;
			end else if (gap_cnt < 1000) begin
				gap_cnt <= gap_cnt + 1;
			end
		end
	end

	sequence s_status_read;
		reg_rd_in && reg_addr_in == REG_POINTER ##1 $stable(internal_operation_flag_out);
	endsequence
	sequence s_ctrl_read_busy;
		internal_operation_flag_out ##1 (internal_operation_flag_out && reg_rd_in
			&& reg_addr_in == REG_CTRL);
	endsequence

	a_status_busy_bit: assert property (s_status_read |-> reg_rdata_out[7] == internal_operation_flag_out)
		else $error("status read busy bit differs from flag");
	a_rdata_one_cycle: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 8'h00)
		else $error("read data present without a read");
	a_unmapped_read: assert property (reg_rd_in && reg_addr_in > REG_DATA |=> reg_rdata_out == 8'h00)
		else $error("unmapped read returned data");
	a_ctrl_reset_busy: assert property (s_ctrl_read_busy |=> reg_rdata_out == 8'h00)
		else $error("control not at reset value while busy");
	a_power_busy: assert property (por_cnt < POWER_CYC |-> internal_operation_flag_out)
		else $error("busy dropped early after power-on");
	a_pin_arm_busy: assert property (!reset_pin_b_in && low_cnt == LOW_CYC
		|-> ##[1:3] internal_operation_flag_out)
		else $error("long reset pin low did not raise busy");
	a_pin_release_busy: assert property ($rose(reset_pin_b_in) && low_cnt > LOW_CYC
		|=> internal_operation_flag_out [*8])
		else $error("busy not held after reset pin release");
	a_one_row_select: assert property ($onehot0({row_driver_out, icon_row_driver_out}))
		else $error("more than one row selected");
	a_row_period: assert property (seen_reg && rows_chg |-> gap_cnt == 72)
		else $error("row latch period wrong");
	a_icon_after_last: assert property ($fell(row_driver_out[15]) |-> icon_row_driver_out)
		else $error("icon row does not follow last text row");
	a_cols_with_latch: assert property ($changed(column_driver_output_out) |-> rows_chg)
		else $error("columns changed outside a latch");
endmodule

bind lgi_glyph_top lgi_glyph_sva #(.LOW_CYC(LOW_CYC), .POWER_CYC(POWER_CYC)) sva_u (
	.core_clk_in(core_clk_in), .rst_b_in(rst_b_in), .reset_pin_b_in(reset_pin_b_in),
	.reg_addr_in(reg_addr_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
	.internal_operation_flag_out(internal_operation_flag_out),
	.column_driver_output_out(column_driver_output_out),
	.row_driver_out(row_driver_out), .icon_row_driver_out(icon_row_driver_out));

// [testbench/lcd_glyph_icon_cursor_init_tb.sv]
// Self-checking bench: host register sequences against glyph, icon, cursor and reset behaviour.
// Assumes shortened sequence counts and the row-zero-only ROM stand-in.
`timescale 1ns/1ps
module lcd_glyph_icon_cursor_init_tb;
	import lgi_pkg::*;
	localparam int P_LOW = 5;
	localparam int P_BUSY = 20;
	localparam logic [59:0] ICONS = 60'h1 | (60'h3 << 57);
	logic clk;
	logic rst_b;
	logic pin_b;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic wr;
	logic rd;
	logic [7:0] rdata;
	logic busy;
	logic [7:0] rom_code;
	logic [2:0] rom_row;
	logic [4:0] rom_data;
	logic [59:0] cols;
	logic [15:0] rows;
	logic icon_row;
	int err_total;
	int total_checks;
	int n;

	lgi_glyph_top #(.LOW_CYC(P_LOW), .POWER_CYC(P_BUSY), .PIN_CYC(P_BUSY), .BLINK_CYC(8)) dut_u (
		.core_clk_in(clk), .rst_b_in(rst_b), .reset_pin_b_in(pin_b),
		.reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd),
		.reg_rdata_out(rdata), .internal_operation_flag_out(busy),
		.fixed_glyph_code_out(rom_code), .fixed_glyph_row_out(rom_row),
		.fixed_glyph_row_in(rom_data), .column_driver_output_out(cols),
		.row_driver_out(rows), .icon_row_driver_out(icon_row));

	lgi_rom_model rom_u (.code_in(rom_code), .row_in(rom_row), .row_out(rom_data));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	task automatic finish_test;
		$display("Checks %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	task automatic chk(input logic [59:0] got, input logic [59:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		@(negedge clk);
		chk(60'(rdata), 60'(e));
	endtask

	task automatic wait_busy(output int cnt);
		cnt = 0;
		@(negedge clk);
		while (busy !== 1'b0) begin
			cnt++;
			if (cnt > 500) begin
				err_total++;
				finish_test;
			end
			@(negedge clk);
		end
	endtask

	// Waits for the row before r to come up anew, so row r is scanned after earlier writes
	task automatic wait_row(input int r);
		logic [16:0] sel;
		int k;
		for (int t = 0; t < 3; t++) begin
			k = 0;
			do begin
				@(negedge clk);
				sel = {icon_row, rows};
				k++;
				if (k > 3000) begin
					err_total++;
					finish_test;
				end
			end while (sel[t == 2 ? r : (r + 16) % 17] !== (t != 0));
		end
	endtask

	task automatic pin_low(input int cyc);
		@(posedge clk);
		pin_b <= 1'b0;
		repeat (cyc) @(posedge clk);
		pin_b <= 1'b1;
	endtask

	initial begin
		rst_b = 1'b0;
		pin_b = 1'b1;
		addr = 4'h0;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		err_total = 0;
		total_checks = 0;
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		wait_busy(n);
		chk(60'(n >= P_BUSY && n <= P_BUSY + 2), 60'h1);
		rd_chk(REG_CTRL, 8'h00);
		rd_chk(REG_POINTER, 8'h00);
		rd_chk(4'hf, 8'h00);
		$display("Test power-on done");
		reg_wr(REG_CTRL, 8'h80);
		reg_wr(REG_POINTER, 8'h88);
		reg_wr(REG_DATA, 8'h11);
		reg_wr(REG_POINTER, 8'h94);
		reg_wr(REG_DATA, 8'h06);
		reg_wr(REG_POINTER, 8'h9f);
		reg_wr(REG_DATA, 8'h10);
		reg_wr(REG_POINTER, 8'h94);
		rd_chk(REG_DATA, 8'h06);
		// Two aliases of user glyph 1, one fixed code, blanks elsewhere
		reg_wr(REG_POINTER, 8'h00);
		for (int i = 0; i < 24; i++) begin
			reg_wr(REG_DATA, i == 0 ? 8'h05 : i == 1 ? 8'h0d : i == 2 ? 8'h31 : 8'h20);
		end
		rd_chk(REG_POINTER, 8'h18);
		reg_wr(REG_POINTER, 8'h03);
		reg_wr(REG_CTRL, 8'h03);
		wait_row(0);
		chk(cols, 60'h4631);
		wait_row(7);
		chk(cols, 60'h1f << 15);
		wait_row(16);
		chk(cols, ICONS);
		$display("Test one-line done");
		reg_wr(REG_CTRL, 8'h0b);
		reg_wr(REG_POINTER, 8'h40);
		reg_wr(REG_DATA, 8'h05);
		rd_chk(REG_POINTER, 8'h41);
		wait_row(8);
		chk(cols, 60'h11);
		wait_row(15);
		chk(cols, 60'h1f << 5);
		reg_wr(REG_POINTER, 8'h81);
		wait_row(7);
		chk(cols, 60'h1f << 5);
		wait_row(16);
		chk(cols, ICONS);
		$display("Test two-line done");
		pin_low(P_LOW);
		repeat (4) begin
			@(negedge clk);
			chk(60'(busy), 60'h0);
		end
		rd_chk(REG_CTRL, 8'h0b);
		pin_low(P_LOW + 3);
		@(negedge clk);
		chk(60'(busy), 60'h1);
		reg_wr(REG_CTRL, 8'h0f);
		rd_chk(REG_CTRL, 8'h00);
		wait_busy(n);
		chk(60'(n >= P_BUSY - 3 && n <= P_BUSY + 1), 60'h1);
		rd_chk(REG_CTRL, 8'h00);
		rd_chk(REG_POINTER, 8'h00);
		reg_wr(REG_POINTER, 8'h94);
		rd_chk(REG_DATA, 8'h06);
		$display("Test pin reset done");
		finish_test;
	end
endmodule
